// ### hw/uart_flow_match.sv
// Receive software flow character matcher, single or paired characters
module uart_flow_match
  import uart_status_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Received character
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  // Mode and characters
  input wire logic [1:0] i_rx_mode,
  input wire logic [7:0] i_char_first,
  input wire logic [7:0] i_char_second,
  // Match result
  output logic o_match
);
  match_state_t state_q;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= MATCH_IDLE;
      o_match <= 1'b0;
    end else if (i_ce) begin
      o_match <= 1'b0;
      if (i_rx_valid) begin
        unique case (i_rx_mode)
          2'b00: state_q <= MATCH_IDLE;
          2'b10: o_match <= (i_rx_char == i_char_first);
          2'b01: o_match <= (i_rx_char == i_char_second);
          2'b11: begin
            // Pair must arrive back to back; mismatch restarts
            if (state_q == MATCH_FIRST && i_rx_char == i_char_second) begin
              o_match <= 1'b1;
              state_q <= MATCH_IDLE;
            end else if (i_rx_char == i_char_first) begin
              state_q <= MATCH_FIRST;
            end else begin
              state_q <= MATCH_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

// ### hw/uart_line_modem_status.sv
// Line and modem status, scratch and enhanced feature registers over AHB-Lite
//
// Notes on behaviour
// - Prescale by 16, extra divide 4 optional
// - Receive-ready while any character is held
// - Overrun when character arrives into full FIFO
// - Parity error reflects FIFO head character
// - Framing error reflects FIFO head character
// - Break sets bit, one break character queued
// - Break means line low whole frame
// - Holding-empty tracks transmit holding/FIFO emptiness
// - Holding-empty interrupt when its enable set
// - Transmit empty needs holding and shifter empty
// - Error summary set by FIFO errors, read-cleared
// - Status bits 2-4 show head character
// - Change bits set on change, read-cleared
// - CTS, DSR, CD changes flag and interrupt
// - Ring change only on rising edge
// - Auto CTS halts after current character
// - Bit 4 inverted CTS, loop: RTS
// - Bit 5 inverted DSR, loop: inverted DTR
// - Bits 6,7 ring/CD, loop: aux outputs
// - Scratch resets 0xFF, may read FIFO count
// - Enhanced register only visible with key 0xBF
// - Enhanced bit 4 gates enhanced bit writes
// - Flow character selection for transmit, receive
// - Modem control bit 4 enters loop-back
// - Enhanced bit 7 enables auto CTS
//
// The register offsets and the AHB-Lite register port were decided locally.
module uart_line_modem_status
  import uart_status_pkg::*;
#(
  parameter int FIFO_LEVEL_W = 8
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Receive datapath status
  input wire logic i_rx_char_done,
  input wire logic [7:0] i_rx_char,
  input wire logic i_rx_parity_bad,
  input wire logic i_rx_stop_bad,
  input wire logic i_rx_line,
  input wire logic i_rx_frame_tick,
  input wire logic i_rx_fifo_full,
  input wire logic i_rx_fifo_empty,
  input wire logic [2:0] i_rx_head_err,
  input wire logic i_rx_any_err,
  input wire logic [FIFO_LEVEL_W-1:0] i_rx_level,
  // Transmit datapath status
  input wire logic i_tx_hold_empty,
  input wire logic i_tx_shift_empty,
  input wire logic i_tx_char_end,
  input wire logic [FIFO_LEVEL_W-1:0] i_tx_level,
  // Modem inputs, active low
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_ri_n,
  input wire logic i_cd_n,
  // Datapath controls
  output logic o_baud_tick,
  output logic o_rx_push,
  output logic o_rx_break_push,
  output logic o_tx_halt,
  output logic o_flow_match,
  output logic [1:0] o_tx_flow_sel,
  output logic o_loopback,
  output logic o_thre_irq,
  output logic o_modem_irq,
  output logic o_rx_overrun_drop
);
  // Bus state
  logic wr_pend_q;
  logic [7:0] wr_addr_q;

  // Registers
  logic [7:0] line_control_q;
  logic [7:0] modem_control_q;
  logic [7:0] scratch_q;
  logic [7:0] enhanced_feature_q;
  logic [7:0] feature_control_q;
  logic [7:0] mode_select_q;
  logic [7:0] interrupt_enable_q;
  logic [7:0] fifo_control_q;
  logic [7:0] resume_char_first_q;
  logic [7:0] resume_char_second_q;
  logic overrun_q;
  logic err_sum_q;
  logic break_q;
  logic [3:0] msr_delta_q;
  logic [3:0] modem_in_q;
  logic tx_halt_q;
  logic lsr_read;
  logic msr_read;

  logic [3:0] modem_now;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic enh_open;
  logic prescale_tick;
  logic match_pulse;

  function automatic logic is_access(input logic sel, input logic [1:0] trans, input logic rdy);
    is_access = sel && trans[1] && rdy;
  endfunction

  function automatic logic [7:0] masked_wr(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] enh_mask, input logic enh_on);
    masked_wr = enh_on ? new_v : ((new_v & ~enh_mask) | (old_v & enh_mask));
  endfunction

  assign enh_open = (line_control_q == ENH_ACCESS_KEY);

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else if (i_ce) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_q <= is_access(i_hsel, i_htrans, i_hready) && i_hwrite;
      wr_addr_q <= i_haddr;
    end
  end

  // Read-clear strobes act in the address phase; data follows one cycle later
  assign lsr_read = i_ce && is_access(i_hsel, i_htrans, i_hready) && !i_hwrite && i_haddr == OFF_LINE_STATUS;
  assign msr_read = i_ce && is_access(i_hsel, i_htrans, i_hready) && !i_hwrite && i_haddr == OFF_MODEM_STATUS;

  // Modem levels, loop-back substitutes control bits
  always_comb begin
    if (modem_control_q[MCR_LOOP]) begin
      modem_now = {modem_control_q[MCR_AUX2], modem_control_q[MCR_AUX1],
                   ~modem_control_q[MCR_DTR], modem_control_q[MCR_RTS]};
    end else begin
      modem_now = {~i_cd_n, ~i_ri_n, ~i_dsr_n, ~i_cts_n};
    end
  end

  assign modem_status = {modem_in_q, msr_delta_q};
  assign line_status = {err_sum_q, i_tx_hold_empty && i_tx_shift_empty, i_tx_hold_empty,
                        i_rx_head_err, overrun_q, !i_rx_fifo_empty};

  // Register writes
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      line_control_q <= 8'h00;
      modem_control_q <= 8'h00;
      scratch_q <= SCRATCH_RESET;
      enhanced_feature_q <= 8'h00;
      feature_control_q <= 8'h00;
      mode_select_q <= 8'h00;
      interrupt_enable_q <= 8'h00;
      fifo_control_q <= 8'h00;
      resume_char_first_q <= 8'h00;
      resume_char_second_q <= 8'h00;
    end else if (i_ce && wr_pend_q) begin
      unique case (wr_addr_q)
        OFF_LINE_CONTROL: line_control_q <= i_hwdata[7:0];
        OFF_MODEM_CONTROL: modem_control_q <= masked_wr(modem_control_q, i_hwdata[7:0], MASK_MCR_ENH,
                                                        enhanced_feature_q[EFR_ENH]);
        OFF_SCRATCH: scratch_q <= i_hwdata[7:0];
        OFF_ENHANCED: if (enh_open) enhanced_feature_q <= i_hwdata[7:0];
        OFF_FEATURE_CTL: if (enh_open) feature_control_q <= i_hwdata[7:0];
        OFF_MODE_SELECT: if (enh_open && feature_control_q[FCTL_SPR_SEL]) mode_select_q <= i_hwdata[7:0];
        OFF_INT_ENABLE: interrupt_enable_q <= masked_wr(interrupt_enable_q, i_hwdata[7:0], MASK_IER_ENH,
                                                        enhanced_feature_q[EFR_ENH]);
        OFF_FIFO_CTL: fifo_control_q <= masked_wr(fifo_control_q, i_hwdata[7:0], MASK_FCR_ENH,
                                                  enhanced_feature_q[EFR_ENH]);
        OFF_FLOW_CHARS: if (enh_open) begin
          resume_char_first_q <= i_hwdata[7:0];
          resume_char_second_q <= i_hwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // Read data registered one cycle after address phase
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_hrdata <= 32'h0000_0000;
      if (is_access(i_hsel, i_htrans, i_hready) && !i_hwrite) begin
        unique case (i_haddr)
          OFF_LINE_CONTROL: o_hrdata[7:0] <= line_control_q;
          OFF_MODEM_CONTROL: o_hrdata[7:0] <= modem_control_q;
          OFF_LINE_STATUS: o_hrdata[7:0] <= line_status;
          OFF_MODEM_STATUS: o_hrdata[7:0] <= modem_status;
          OFF_SCRATCH: begin
            if (feature_control_q[FCTL_SPR_SEL]) begin
              o_hrdata[7:0] <= mode_select_q[0] ? 8'(i_tx_level) : 8'(i_rx_level);
            end else begin
              o_hrdata[7:0] <= scratch_q;
            end
          end
          OFF_ENHANCED: o_hrdata[7:0] <= enh_open ? enhanced_feature_q : 8'h00;
          OFF_FEATURE_CTL: o_hrdata[7:0] <= enh_open ? feature_control_q : 8'h00;
          OFF_INT_ENABLE: o_hrdata[7:0] <= interrupt_enable_q;
          OFF_FIFO_CTL: o_hrdata[7:0] <= fifo_control_q;
          OFF_FLOW_CHARS: o_hrdata[15:0] <= {resume_char_second_q, resume_char_first_q};
          OFF_FLOW_STATE: o_hrdata[7:0] <= {6'h00, tx_halt_q, match_pulse};
          default: ;
        endcase
      end
    end
  end

  // Line status flags: set wins over read-clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun_q <= 1'b0;
      err_sum_q <= 1'b0;
      o_rx_push <= 1'b0;
      o_rx_overrun_drop <= 1'b0;
    end else if (i_ce) begin
      o_rx_push <= i_rx_char_done && !i_rx_fifo_full;
      o_rx_overrun_drop <= i_rx_char_done && i_rx_fifo_full;
      if (i_rx_char_done && i_rx_fifo_full) begin
        overrun_q <= 1'b1;
      end else if (lsr_read) begin
        overrun_q <= 1'b0;
      end
      if (i_rx_any_err || (i_rx_char_done && (i_rx_parity_bad || i_rx_stop_bad))) begin
        err_sum_q <= 1'b1;
      end else if (lsr_read) begin
        err_sum_q <= 1'b0;
      end
    end
  end

  // Break: line low for a whole frame, one character queued
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      break_q <= 1'b0;
      o_rx_break_push <= 1'b0;
    end else if (i_ce) begin
      o_rx_break_push <= 1'b0;
      if (i_rx_line) begin
        break_q <= 1'b0;
      end else if (i_rx_frame_tick && !break_q) begin
        break_q <= 1'b1;
        o_rx_break_push <= !i_rx_fifo_full;
      end
    end
  end

  // Modem change detection
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      modem_in_q <= 4'h0;
      msr_delta_q <= 4'h0;
    end else if (i_ce) begin
      modem_in_q <= modem_now;
      for (int i = 0; i < 4; i++) begin
        if ((i == 2) ? (!modem_now[i] && modem_in_q[i]) : (modem_now[i] != modem_in_q[i])) begin
          msr_delta_q[i] <= 1'b1;
        end else if (msr_read) begin
          msr_delta_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt requests and auto CTS halt
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_thre_irq <= 1'b0;
      o_modem_irq <= 1'b0;
      tx_halt_q <= 1'b0;
      o_tx_halt <= 1'b0;
      o_loopback <= 1'b0;
      o_tx_flow_sel <= 2'b00;
      o_flow_match <= 1'b0;
    end else if (i_ce) begin
      o_thre_irq <= i_tx_hold_empty && interrupt_enable_q[IER_THRE];
      o_modem_irq <= (|msr_delta_q) && interrupt_enable_q[IER_MODEM];
      o_loopback <= modem_control_q[MCR_LOOP];
      o_tx_flow_sel <= enhanced_feature_q[3:2];
      o_flow_match <= match_pulse;
      // Inverted level: high means the pin is low, so sending may resume
      if (!enhanced_feature_q[EFR_AUTO_CTS] || modem_now[0]) begin
        tx_halt_q <= 1'b0;
      end else if (i_tx_char_end || i_tx_shift_empty) begin
        tx_halt_q <= 1'b1;
      end
      o_tx_halt <= tx_halt_q;
    end
  end

  assign o_baud_tick = prescale_tick;

  uart_prescaler u_prescaler (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_div4(modem_control_q[MCR_PRESCALE]),
    .o_tick(prescale_tick)
  );

  uart_flow_match u_match (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_rx_valid(i_rx_char_done),
    .i_rx_char(i_rx_char),
    .i_rx_mode(enhanced_feature_q[1:0]),
    .i_char_first(resume_char_first_q),
    .i_char_second(resume_char_second_q),
    .o_match(match_pulse)
  );

  // Checks
  a_overrun_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_rx_char_done && i_rx_fifo_full |=> overrun_q && !o_rx_push) else $error("overrun not flagged");
  a_ring_rise_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !msr_delta_q[2] && !(!modem_now[2] && modem_in_q[2]) |=> !msr_delta_q[2]) else $error("ring bad set");
  a_cts_delta: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && modem_now[0] != modem_in_q[0] |=> msr_delta_q[0]) else $error("cts change lost");
  a_msr_read_clr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && msr_read && modem_now == modem_in_q |=> msr_delta_q == 4'h0) else $error("delta not cleared");
  a_loop_rts: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && modem_control_q[MCR_LOOP] |=> modem_status[4] == $past(modem_control_q[MCR_RTS]))
    else $error("loop cts wrong");
  a_scratch_fifo: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && is_access(i_hsel, i_htrans, i_hready) && !i_hwrite && i_haddr == OFF_SCRATCH
    && feature_control_q[FCTL_SPR_SEL] && !mode_select_q[0] |=> o_hrdata[7:0] == 8'($past(i_rx_level)))
    else $error("fifo count read wrong");
  a_thre_irq: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_tx_hold_empty && interrupt_enable_q[IER_THRE] |=> o_thre_irq) else $error("thre irq missing");
  a_cts_resume: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && modem_now[0] |=> !tx_halt_q) else $error("halt held with cts low");
endmodule

// ### hw/uart_prescaler.sv
// Baud clock prescaler: divide by 16, optionally by a further 4
module uart_prescaler
  import uart_status_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Control
  input wire logic i_div4,
  // Tick out
  output logic o_tick
);
  logic [3:0] base_q;
  logic [1:0] extra_q;
  logic base_wrap;
  assign base_wrap = (base_q == 4'(PRESCALE_BASE - 1));

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      base_q <= 4'h0;
      extra_q <= 2'h0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      base_q <= base_q + 4'h1;
      if (base_wrap) begin
        extra_q <= extra_q + 2'h1;
      end
      // Extra divide only when prescale bit set
      o_tick <= base_wrap && (!i_div4 || extra_q == 2'(PRESCALE_EXTRA - 1));
    end
  end
endmodule

// ### hw/uart_status_pkg.sv
// Package: register map, field positions, reset values for the status slice
package uart_status_pkg;
  // Register byte offsets (chosen)
  localparam logic [7:0] OFF_LINE_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODEM_CONTROL = 8'h04;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h08;
  localparam logic [7:0] OFF_MODEM_STATUS = 8'h0C;
  localparam logic [7:0] OFF_SCRATCH = 8'h10;
  localparam logic [7:0] OFF_ENHANCED = 8'h14;
  localparam logic [7:0] OFF_FEATURE_CTL = 8'h18;
  localparam logic [7:0] OFF_MODE_SELECT = 8'h1C;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h20;
  localparam logic [7:0] OFF_FIFO_CTL = 8'h24;
  localparam logic [7:0] OFF_FLOW_CHARS = 8'h28;
  localparam logic [7:0] OFF_FLOW_STATE = 8'h2C;
  // Values and fields
  localparam logic [7:0] ENH_ACCESS_KEY = 8'hBF;
  localparam logic [7:0] SCRATCH_RESET = 8'hFF;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_AUX1 = 2;
  localparam int MCR_AUX2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_PRESCALE = 7;
  localparam int EFR_ENH = 4;
  localparam int EFR_AUTO_CTS = 7;
  localparam int FCTL_SPR_SEL = 6;
  localparam int IER_THRE = 1;
  localparam int IER_MODEM = 3;
  localparam logic [7:0] MASK_IER_ENH = 8'hF0;
  localparam logic [7:0] MASK_FCR_ENH = 8'h30;
  localparam logic [7:0] MASK_MCR_ENH = 8'hE0;
  // Prescale divisors
  localparam int PRESCALE_BASE = 16;
  localparam int PRESCALE_EXTRA = 4;
  // Receive flow match states
  typedef enum logic [1:0] {
    MATCH_IDLE = 2'b00,
    MATCH_FIRST = 2'b01
  } match_state_t;
endpackage

// ### tb/modem_peer.sv
// Modem-side peer: drives the four active-low modem status lines
module modem_peer (
  // Clock
  input wire logic i_core_clk,
  // Requested levels {cd, ri, dsr, cts}
  input wire logic [3:0] i_levels,
  // Modem lines, active low
  output logic o_cts_n,
  output logic o_dsr_n,
  output logic o_ri_n,
  output logic o_cd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle modem keeps every line deasserted
  initial begin
    {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} = 4'hF;
  end
  // Lines move only after an edge, never on it
  always @(posedge i_core_clk) begin
    {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} <= i_levels;
  end
endmodule

// ### tb/uart_line_modem_status_tb.sv
// Self-checking bench for the line and modem status slice
module uart_line_modem_status_tb;
  import uart_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, rdy_smp, tick_smp;
  logic [7:0] haddr, rxc, rx_lvl, tx_lvl;
  logic [1:0] htrans, flow_sel;
  logic [2:0] hsize, rx_head;
  logic [31:0] hwdata, hrdata, rd_smp, seed;
  logic rx_done, rx_pbad, rx_sbad, rx_line, rx_ftick, rx_full, rx_empty, rx_anyerr;
  logic tx_hempty, tx_sempty, tx_cend, cts_n, dsr_n, ri_n, cd_n;
  logic tick, push, brk, halt, match, loopb, thre_irq, modem_irq, drop;
  logic [3:0] pins, msr_delta, lvl;
  logic [7:0] f1, r;
  int n_mismatch, check_count, drop_cnt, push_cnt, brk_cnt, match_cnt, c, i, p0;
  uart_line_modem_status #(.FIFO_LEVEL_W(8)) u_uart_line_modem_status (
    .i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_rx_char_done(rx_done), .i_rx_char(rxc),
    .i_rx_parity_bad(rx_pbad), .i_rx_stop_bad(rx_sbad), .i_rx_line(rx_line), .i_rx_frame_tick(rx_ftick),
    .i_rx_fifo_full(rx_full), .i_rx_fifo_empty(rx_empty), .i_rx_head_err(rx_head), .i_rx_any_err(rx_anyerr),
    .i_rx_level(rx_lvl), .i_tx_hold_empty(tx_hempty), .i_tx_shift_empty(tx_sempty), .i_tx_char_end(tx_cend),
    .i_tx_level(tx_lvl), .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ri_n(ri_n), .i_cd_n(cd_n), .o_baud_tick(tick),
    .o_rx_push(push), .o_rx_break_push(brk), .o_tx_halt(halt), .o_flow_match(match), .o_tx_flow_sel(flow_sel),
    .o_loopback(loopb), .o_thre_irq(thre_irq), .o_modem_irq(modem_irq), .o_rx_overrun_drop(drop));
  modem_peer u_modem_peer (.i_core_clk(clk), .i_levels(pins), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
    .o_ri_n(ri_n), .o_cd_n(cd_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Samples taken by NBA hold the pre-edge values, so no race with the design
  always @(posedge clk) begin
    rd_smp <= hrdata;
    rdy_smp <= hreadyout;
    tick_smp <= tick;
    drop_cnt <= drop_cnt + int'(drop);
    push_cnt <= push_cnt + int'(push);
    brk_cnt <= brk_cnt + int'(brk);
    match_cnt <= match_cnt + int'(match);
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] lsr_exp(input logic ovr, input logic sum);
    return {24'h0, sum, tx_hempty & tx_sempty, tx_hempty, rx_head, ovr, ~rx_empty};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_sig(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  // Bounded wait for hready; an exhausted wait ends the run
  task automatic wait_rdy();
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      #1;
      if (rdy_smp === 1'b1) break;
    end
    if (k == 50) begin
      chk_sig(1'b0, 1'b1);
      stop_test();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = rd_smp;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    ahb(1'b1, a, v, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk_reg(d, e);
  endtask
  // Model of the change flags on inverted levels: ring flags only when its pin rises
  task automatic lvl_to(input logic [3:0] nl);
    msr_delta = msr_delta | ((lvl ^ nl) & 4'b1011) | (lvl & ~nl & 4'b0100);
    lvl = nl;
  endtask
  task automatic set_pins(input logic [3:0] p);
    lvl_to(~p);
    pins <= p;
    repeat (4) @(posedge clk);
  endtask
  task automatic msr_chk();
    rd_chk(OFF_MODEM_STATUS, {24'h0, ~pins, msr_delta});
    msr_delta = 4'h0;
  endtask
  task automatic send_char(input logic [7:0] ch);
    @(posedge clk);
    rx_done <= 1'b1;
    rxc <= ch;
    @(posedge clk);
    rx_done <= 1'b0;
  endtask
  // Cycles from one baud tick to the next, third interval after any change
  task automatic period(output int n);
    int k;
    repeat (3) begin
      n = 0;
      for (k = 0; k < 200 && tick_smp !== 1'b1 || n == 0; k++) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (k >= 200) begin
        chk_sig(1'b0, 1'b1);
        stop_test();
      end
    end
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, hsize} = {1'b0, 1'b0, 8'h00, 2'b00, 32'h0, 3'b010};
    {rx_done, rxc, rx_pbad, rx_sbad, rx_line, rx_ftick, rx_full, rx_empty} = {10'h000, 5'b01001};
    {rx_head, rx_anyerr, tx_hempty, tx_sempty, tx_cend} = 7'b0000110;
    {pins, msr_delta, lvl, n_mismatch, check_count} = {8'hF0, 68'h0};
    {drop_cnt, push_cnt, brk_cnt, match_cnt} = 128'h0;
    seed = xs(32'h2dcdbb8a);
    rx_lvl = seed[7:0];
    seed = xs(seed);
    tx_lvl = seed[7:0];
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFF_SCRATCH, 32'hFF);
    rd_chk(OFF_LINE_STATUS, lsr_exp(1'b0, 1'b0));
    msr_chk();
    rd_chk(8'h3C, 32'h0);
    rd_chk(OFF_ENHANCED, 32'h0);
    chk_sig(hresp, 1'b0);
    tend("reset");
    period(c);
    chk_reg(32'(c), 32'(PRESCALE_BASE));
    wr(OFF_MODEM_CONTROL, 32'h80);
    period(c);
    chk_reg(32'(c), 32'(PRESCALE_BASE));
    wr(OFF_LINE_CONTROL, 32'hBF);
    wr(OFF_ENHANCED, 32'h10);
    wr(OFF_LINE_CONTROL, 32'h00);
    wr(OFF_MODEM_CONTROL, 32'h80);
    period(c);
    chk_reg(32'(c), 32'(PRESCALE_BASE * PRESCALE_EXTRA));
    tend("prescale");
    wr(OFF_INT_ENABLE, 32'h08);
    set_pins(4'b0000);
    chk_sig(modem_irq, 1'b1);
    msr_chk();
    repeat (2) @(posedge clk);
    chk_sig(modem_irq, 1'b0);
    set_pins(4'b0100);
    msr_chk();
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      lvl_to({seed[3], seed[2], ~seed[0], seed[1]});
      wr(OFF_MODEM_CONTROL, {28'h1, seed[3:0]});
      rd_chk(OFF_MODEM_STATUS, {24'h0, lvl, msr_delta});
      msr_delta = 4'h0;
      chk_sig(loopb, 1'b1);
    end
    wr(OFF_MODEM_CONTROL, 32'h00);
    lvl_to(~pins);
    msr_chk();
    rd_chk(OFF_MODEM_STATUS, {24'h0, ~pins, 4'h0});
    tend("modem");
    {rx_empty, rx_head, rx_anyerr, tx_sempty} <= 6'b010110;
    repeat (2) @(posedge clk);
    rx_anyerr <= 1'b0;
    rd_chk(OFF_LINE_STATUS, lsr_exp(1'b0, 1'b1));
    rd_chk(OFF_LINE_STATUS, lsr_exp(1'b0, 1'b0));
    rx_head <= 3'b010;
    rx_full <= 1'b1;
    p0 = push_cnt;
    send_char(8'h5A);
    repeat (3) @(posedge clk);
    chk_reg(32'(drop_cnt), 32'h1);
    chk_reg(32'(push_cnt - p0), 32'h0);
    rd_chk(OFF_LINE_STATUS, lsr_exp(1'b1, 1'b0));
    rd_chk(OFF_LINE_STATUS, lsr_exp(1'b0, 1'b0));
    rx_full <= 1'b0;
    rx_line <= 1'b0;
    send_char(8'hA5);
    repeat (2) begin
      rx_ftick <= 1'b1;
      @(posedge clk);
      rx_ftick <= 1'b0;
      repeat (3) @(posedge clk);
    end
    rx_line <= 1'b1;
    chk_reg(32'(push_cnt - p0), 32'h1);
    chk_reg(32'(brk_cnt), 32'h1);
    tend("line status");
    wr(OFF_INT_ENABLE, 32'h0A);
    repeat (2) @(posedge clk);
    chk_sig(thre_irq, 1'b1);
    tx_hempty <= 1'b0;
    repeat (2) @(posedge clk);
    chk_sig(thre_irq, 1'b0);
    rd_chk(OFF_LINE_STATUS, lsr_exp(1'b0, 1'b0));
    tx_hempty <= 1'b1;
    tend("transmit status");
    wr(OFF_LINE_CONTROL, 32'hBF);
    for (i = 0; i < 4; i++) begin
      wr(OFF_ENHANCED, 32'h10 | 32'(i << 2));
      rd_chk(OFF_ENHANCED, 32'h10 | 32'(i << 2));
      chk_reg({30'h0, flow_sel}, 32'(i));
    end
    seed = xs(seed);
    f1 = seed[7:0];
    wr(OFF_FLOW_CHARS, {16'h0, f1 ^ 8'h5C, f1});
    wr(OFF_ENHANCED, 32'h13);
    p0 = match_cnt;
    send_char(f1);
    send_char(f1 ^ 8'h5C);
    repeat (4) @(posedge clk);
    chk_reg(32'(match_cnt - p0), 32'h1);
    send_char(f1);
    send_char(f1 ^ 8'h01);
    send_char(f1 ^ 8'h5C);
    repeat (4) @(posedge clk);
    chk_reg(32'(match_cnt - p0), 32'h1);
    wr(OFF_ENHANCED, 32'h11);
    send_char(f1);
    send_char(f1 ^ 8'h5C);
    repeat (4) @(posedge clk);
    chk_reg(32'(match_cnt - p0), 32'h2);
    wr(OFF_ENHANCED, 32'h12);
    send_char(f1 ^ 8'h5C);
    send_char(f1);
    repeat (4) @(posedge clk);
    chk_reg(32'(match_cnt - p0), 32'h3);
    wr(OFF_ENHANCED, 32'h90);
    set_pins(4'b0101);
    tx_cend <= 1'b1;
    @(posedge clk);
    tx_cend <= 1'b0;
    repeat (3) @(posedge clk);
    chk_sig(halt, 1'b1);
    set_pins(4'b0100);
    chk_sig(halt, 1'b0);
    tend("enhanced");
    r = seed[15:8];
    wr(OFF_SCRATCH, {24'h0, r});
    rd_chk(OFF_SCRATCH, {24'h0, r});
    wr(OFF_FEATURE_CTL, 32'h40);
    wr(OFF_MODE_SELECT, 32'h01);
    rd_chk(OFF_SCRATCH, {24'h0, tx_lvl});
    wr(OFF_MODE_SELECT, 32'h00);
    rd_chk(OFF_SCRATCH, {24'h0, rx_lvl});
    wr(OFF_FEATURE_CTL, 32'h00);
    rd_chk(OFF_SCRATCH, {24'h0, r});
    wr(OFF_LINE_CONTROL, 32'h00);
    rd_chk(OFF_ENHANCED, 32'h0);
    tend("scratch");
    stop_test();
  end
endmodule
